// *** verilog/lfss_sequencer.sv ***
// fault and soft-start sequencer for a switching led driver
// assumes comparator levels arrive asynchronously; dimming input is
// synchronous to sys_clk, which ticks once per nominal switch period
`timescale 1ns/100ps
`include "lfss_defines.svh"

// Contract
// - short, overvoltage or overcurrent stops switching, opens load, flags
// - serious-fault shutdown acts at once, not at cycle end; short skips the raw path and waits for the synchroniser
// - open led only flags; switching and load continue
// - sense drop above 700mV reports overcurrent
// - feedback below 300mV reports short, not during start-up
// - feedback 1.17V to 1.3V with sense under 25mV reports open
// - feedback above 1.3V reports overvoltage
// - every fault pulls the open-drain flag low; outside pulls up
// - after short or overcurrent, cool down then full soft-start
// - cooldown lasts at least 32768 nominal switch periods
// - flag stays set through fault restart until clean finish
// - soft-start begins near 40% frequency, near-zero limit, relaxes
// - soft-start is 1024 cycles, stepping every 16
// - every soft-start waits for the first dimming pulse
// - soft-start ignores dimming low until done or 10% current
// - enable low stops switching, resets soft-start, opens load
// - negative sense below 2.5V disables open and short detection
// - over-temperature stops, resets soft-start, opens load
module lfss_sequencer
  import lfss_pkg::*;
#(
  parameter int COOLDOWN_PERIODS = `LFSS_COOLDOWN_PERIODS
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enableIn,
  input wire logic dimPwm,
  input wire logic cmpOverCurrent,
  input wire logic cmpFbLow,
  input wire logic cmpFbOpenBand,
  input wire logic cmpSenseLow,
  input wire logic cmpOverVolt,
  input wire logic cmpSenseNegLow,
  input wire logic cmpOverTemp,
  input wire logic cmpTenPercent,
  output logic switchEnable,
  output logic loadDisconnectGate,
  output logic faultFlagOut,
  output logic faultFlagOe,
  output logic softStartActive,
  output logic [5:0] freqSet,
  output logic [5:0] ilimSet
);
  localparam int CCW = $clog2(COOLDOWN_PERIODS) + 1;

  lfss_cmp_s cmpRaw, cmp;
  lfss_state_e state_r, state_nxt;
  logic [CCW-1:0] cool_r, cool_nxt;
  logic flag_r, flag_nxt;
  logic restart_r, restart_nxt;
  logic ssBypass_r, ssBypass_nxt;
  logic sw_r, sw_nxt, load_r, load_nxt;
  logic ssActive_r;
  logic [5:0] freq_r, ilim_r;
  logic rampClear, rampRun, rampDone;
  logic [5:0] rampFreq, rampIlim;
  logic detOc, detShort, detOpen, detOv, hiccup, stopNow, anyFault;
  logic fastKill;

  // --------------------------------------------------
  // comparator synchronisation
  // --------------------------------------------------
  assign cmpRaw = '{overCurrent: cmpOverCurrent, fbLow: cmpFbLow,
                    fbOpenBand: cmpFbOpenBand, senseLow: cmpSenseLow,
                    overVolt: cmpOverVolt, senseNegLow: cmpSenseNegLow,
                    overTemp: cmpOverTemp, tenPercent: cmpTenPercent};

  lfss_sync #(.WIDTH($bits(lfss_cmp_s))) uSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(cmpRaw),
    .syncOut(cmp)
  );

  // --------------------------------------------------
  // fault decode
  // --------------------------------------------------
  // short and open are blinded while the negative sense node is low
  assign detOc = cmp.overCurrent;
  assign detOv = cmp.overVolt;
  assign detShort = cmp.fbLow && !cmp.senseNegLow &&
                    state_r == LFSS_RUN;
  assign detOpen = cmp.fbOpenBand && cmp.senseLow &&
                   !cmp.senseNegLow;
  assign hiccup = detOc || detShort;
  assign stopNow = hiccup || detOv || cmp.overTemp;
  assign anyFault = stopNow || detOpen;

  // raw comparators clear the switch at once; a glitch only costs a
  // pulse, and the registered path then decides the sequence
  assign fastKill = cmpOverCurrent || cmpOverVolt ||
                    cmpOverTemp;

  // --------------------------------------------------
  // sequence state, cooldown and flag
  // --------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cool_nxt = cool_r;
    flag_nxt = flag_r;
    restart_nxt = restart_r;
    ssBypass_nxt = ssBypass_r;
    case (state_r)
      LFSS_OFF: begin
        if (enableIn)
          state_nxt = LFSS_WAIT_DIM;
      end
      LFSS_WAIT_DIM: begin
        ssBypass_nxt = 1'b0;
        if (dimPwm)
          state_nxt = LFSS_SOFT;
      end
      LFSS_SOFT: begin
        if (cmp.tenPercent)
          ssBypass_nxt = 1'b1;
        if (rampDone)
          state_nxt = LFSS_RUN;
      end
      LFSS_RUN: begin
      end
      LFSS_COOL: begin
        if (cool_r == CCW'(COOLDOWN_PERIODS - 1))
          state_nxt = LFSS_WAIT_DIM;
        else
          cool_nxt = cool_r + 1'b1;
      end
      default: state_nxt = LFSS_OFF;
    endcase
    // serious faults override the sequence from any state but off and cooldown
    if (state_r != LFSS_OFF && state_r != LFSS_COOL && stopNow) begin
      restart_nxt = 1'b1;
      cool_nxt = '0;
      state_nxt = hiccup ? LFSS_COOL : LFSS_WAIT_DIM;
    end
    if (!enableIn) begin
      state_nxt = LFSS_OFF;
      restart_nxt = 1'b0;
    end
    // flag: set by any fault, held across a restart until clean finish
    if (anyFault)
      flag_nxt = 1'b1;
    else if (state_r == LFSS_SOFT && rampDone)
      flag_nxt = 1'b0;
    else if (!restart_r && state_r == LFSS_RUN)
      flag_nxt = 1'b0;
    if (state_r == LFSS_SOFT && rampDone && !anyFault)
      restart_nxt = 1'b0;
  end

  // --------------------------------------------------
  // ramp control
  // --------------------------------------------------
  assign rampClear = state_r != LFSS_SOFT;
  assign rampRun = state_r == LFSS_SOFT;

  lfss_ramp uRamp (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(rampClear),
    .run(rampRun),
    .done(rampDone),
    .freqSet(rampFreq),
    .ilimSet(rampIlim)
  );

  // --------------------------------------------------
  // drive outputs
  // --------------------------------------------------
  // open led never enters here, so it leaves switching alone
  always_comb begin
    sw_nxt = 1'b0;
    load_nxt = 1'b0;
    case (state_nxt)
      LFSS_SOFT: begin
        sw_nxt = dimPwm || !ssBypass_nxt;
        load_nxt = sw_nxt;
      end
      LFSS_RUN: begin
        sw_nxt = dimPwm;
        load_nxt = dimPwm;
      end
      default: begin
        sw_nxt = 1'b0;
        load_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= LFSS_OFF;
      cool_r <= '0;
      flag_r <= 1'b0;
      restart_r <= 1'b0;
      ssBypass_r <= 1'b0;
      sw_r <= 1'b0;
      load_r <= 1'b0;
      ssActive_r <= 1'b0;
      freq_r <= `LFSS_FREQ_START;
      ilim_r <= `LFSS_ILIM_START;
    end else begin
      state_r <= state_nxt;
      cool_r <= cool_nxt;
      flag_r <= flag_nxt;
      restart_r <= restart_nxt;
      ssBypass_r <= ssBypass_nxt;
      sw_r <= sw_nxt && !fastKill;
      load_r <= load_nxt && !fastKill;
      ssActive_r <= state_nxt == LFSS_SOFT;
      // the ramp clears once it leaves soft-start, so steady running
      // holds the nominal settings instead of the ramp's start values
      freq_r <= (state_nxt == LFSS_RUN) ? `LFSS_FREQ_NOM :
                rampFreq;
      ilim_r <= (state_nxt == LFSS_RUN) ? 6'h3F : rampIlim;
    end
  end

  assign switchEnable = sw_r;
  assign loadDisconnectGate = load_r;
  assign faultFlagOut = 1'b0; // open drain only ever pulls low
  assign faultFlagOe = flag_r;
  assign softStartActive = ssActive_r;
  assign freqSet = freq_r;
  assign ilimSet = ilim_r;
endmodule

// *** verilog/lfss_defines.svh ***
// constants for the led fault and soft-start sequencer
// assumes the switching clock is the sequencer clock, one tick per period
`ifndef LFSS_DEFINES_SVH
`define LFSS_DEFINES_SVH
// cooldown length in nominal switching periods
`define LFSS_COOLDOWN_PERIODS 32768
// soft-start total cycles and cycles per step
`define LFSS_SS_CYCLES 1024
`define LFSS_SS_STEP_CYCLES 16
`define LFSS_SS_STEPS 64
// starting frequency setting, about 40 percent of nominal (of 63)
`define LFSS_FREQ_START 6'h19
`define LFSS_FREQ_NOM 6'h3F
`define LFSS_ILIM_START 6'h00
`endif

// *** verilog/lfss_pkg.sv ***
// types shared by the sequencer files
// assumes the defines header is compiled alongside
package lfss_pkg;
  typedef enum {
    LFSS_OFF, LFSS_WAIT_DIM, LFSS_SOFT, LFSS_RUN, LFSS_COOL
  } lfss_state_e;
  // synchronised comparator results
  typedef struct packed {
    logic overCurrent;
    logic fbLow;
    logic fbOpenBand;
    logic senseLow;
    logic overVolt;
    logic senseNegLow;
    logic overTemp;
    logic tenPercent;
  } lfss_cmp_s;
endpackage

// *** verilog/lfss_sync.sv ***
// two-flop synchroniser for a bundle of comparator levels
// assumes the inputs are asynchronous levels
`timescale 1ns/100ps
module lfss_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // --------------------------------------------------
  // first stage feeds only the second
  // --------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= asyncIn;
      sync_r <= meta_r;
    end
  end
  assign syncOut = sync_r;
endmodule

// *** verilog/lfss_ramp.sv ***
// soft-start ramp: step counter and frequency/current-limit settings
// assumes clear high outside soft-start, run high while soft-start is active
`timescale 1ns/100ps
`include "lfss_defines.svh"
module lfss_ramp #(
  parameter int SS_CYCLES = `LFSS_SS_CYCLES,
  parameter int STEP_CYCLES = `LFSS_SS_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic run,
  output logic done,
  output logic [5:0] freqSet,
  output logic [5:0] ilimSet
);
  localparam int CW = $clog2(SS_CYCLES) + 1;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [5:0] freq_r, freq_nxt, ilim_r, ilim_nxt;

  // --------------------------------------------------
  // step every STEP_CYCLES, monotonic toward nominal
  // --------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    freq_nxt = freq_r;
    ilim_nxt = ilim_r;
    if (clear) begin
      cnt_nxt = '0;
      freq_nxt = `LFSS_FREQ_START;
      ilim_nxt = `LFSS_ILIM_START;
    end else if (run && cnt_r < CW'(SS_CYCLES)) begin
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_r[3:0] == 4'(STEP_CYCLES - 1)) begin
        // saturate so the ramp never wraps back down
        if (freq_r != `LFSS_FREQ_NOM)
          freq_nxt = freq_r + 6'h01;
        if (ilim_r != 6'h3F)
          ilim_nxt = ilim_r + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      freq_r <= `LFSS_FREQ_START;
      ilim_r <= `LFSS_ILIM_START;
    end else begin
      cnt_r <= cnt_nxt;
      freq_r <= freq_nxt;
      ilim_r <= ilim_nxt;
    end
  end
  assign done = (cnt_r == CW'(SS_CYCLES));
  // the limit reaches full one step before the last; done forces both settings to full at the end
  assign freqSet = done ? `LFSS_FREQ_NOM : freq_r;
  assign ilimSet = done ? 6'h3F : ilim_r;
endmodule

// *** bench/lfss_sequencer_properties.sv ***
// checker on the sequencer top-level ports
// assumes one clock domain; bound onto every lfss_sequencer
`timescale 1ns/100ps
`include "lfss_defines.svh"
module lfss_props #(
  parameter int COOLDOWN_PERIODS = 64
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enableIn,
  input wire logic dimPwm,
  input wire logic cmpOverCurrent,
  input wire logic cmpFbLow,
  input wire logic cmpFbOpenBand,
  input wire logic cmpSenseLow,
  input wire logic cmpOverVolt,
  input wire logic cmpSenseNegLow,
  input wire logic cmpOverTemp,
  input wire logic cmpTenPercent,
  input wire logic switchEnable,
  input wire logic loadDisconnectGate,
  input wire logic faultFlagOut,
  input wire logic faultFlagOe,
  input wire logic softStartActive,
  input wire logic [5:0] freqSet,
  input wire logic [5:0] ilimSet
);
  logic [11:0] ssCnt_r;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // soft-start run length, so the assertion needs no long repetition
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      ssCnt_r <= 12'h000;
    else
      ssCnt_r <= softStartActive ? ssCnt_r + 12'h001 : 12'h000;
  end
  // ----------
  // assertions
  // ----------
  a_oc_stop: assert property (
    cmpOverCurrent |=> !switchEnable && !loadDisconnectGate)
    else $error("overcurrent did not stop");
  a_ov_stop: assert property (
    cmpOverVolt |=> !switchEnable) else $error("overvoltage did not stop");
  a_en_off: assert property (
    !enableIn |-> ##[1:2] !switchEnable && !softStartActive)
    else $error("enable low did not stop");
  a_ov_flag: assert property (
    (cmpOverVolt && enableIn)[*3] |=> faultFlagOe && !faultFlagOut)
    else $error("flag not pulled");
  a_ss_gate: assert property (
    $rose(softStartActive) |-> $past(dimPwm) && ilimSet == `LFSS_ILIM_START
    && freqSet == `LFSS_FREQ_START) else $error("bad soft-start entry");
  a_ss_len: assert property (
    $fell(softStartActive) && loadDisconnectGate |-> freqSet == 6'h3F
    && ssCnt_r inside {[12'h400:12'h401]}) else $error("bad ramp length");
  a_ramp_mono: assert property (
    softStartActive && $past(softStartActive) |-> freqSet >= $past(freqSet)
    && ilimSet >= $past(ilimSet)) else $error("ramp went down");
  a_flag_hold: assert property (
    softStartActive && $past(softStartActive) && $past(faultFlagOe)
    |-> faultFlagOe) else $error("flag dropped in soft-start");
  c_ss_start: cover property ($rose(softStartActive));
  c_ss_done: cover property ($fell(softStartActive) && loadDisconnectGate);
  c_flag: cover property ($rose(faultFlagOe));
endmodule
bind lfss_sequencer lfss_props #(
  .COOLDOWN_PERIODS(COOLDOWN_PERIODS)
) u_props (.*);

// *** bench/lfss_host_model.sv ***
// system controller: dimming source and fault-line pull-up
// assumes dimMode comes from the bench; flag pin is open drain
`timescale 1ns/100ps
module lfss_host_model (
  input wire logic sys_clk,
  input wire logic [1:0] dimMode,
  input wire logic faultFlagOut,
  input wire logic faultFlagOe,
  output logic dimPwm = 1'b0,
  output logic faultLine
);
  logic [3:0] ph_r = 4'h0;
  // pull-up holds the line high unless a device pulls it
  assign faultLine = faultFlagOe ? faultFlagOut : 1'b1;
  // mode 0 low, 1 steady high, 2 pulse train; first pulse starts power-up
  always_ff @(posedge sys_clk) begin
    ph_r <= ph_r + 4'h1;
    dimPwm <= dimMode == 2'h1 || (dimMode == 2'h2 && ph_r < 4'h4);
  end
endmodule

// *** bench/tb_led_fault_softstart_sequencer.sv ***
// self-checking bench for the fault and soft-start sequencer
// assumes the host model drives dimming and pulls up the fault line
`timescale 1ns/100ps
module tb_led_fault_softstart_sequencer;
  logic sys_clk = 1'b0, rstn = 1'b0, enableIn = 1'b0;
  logic cmpOverCurrent = 1'b0, cmpFbLow = 1'b0, cmpFbOpenBand = 1'b0;
  logic cmpSenseLow = 1'b0, cmpOverVolt = 1'b0, cmpSenseNegLow = 1'b0;
  logic cmpOverTemp = 1'b0, cmpTenPercent = 1'b0;
  logic [1:0] dimMode = 2'h0;
  logic dimPwm, faultLine, switchEnable, loadDisconnectGate;
  logic faultFlagOut, faultFlagOe, softStartActive;
  logic [5:0] freqSet, ilimSet;
  int num_errors = 0, compares = 0, seed = 32'hb275, n, h;
  // short cooldown keeps the run brief
  lfss_sequencer #(.COOLDOWN_PERIODS(64)) u_dut (.*);
  lfss_host_model u_host (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic end_sim;
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for switching (s=0) or soft-start (s=1) to reach v
  task automatic waitFor(input int s, input logic v, input int lim);
    n = 0;
    while ((s == 0 ? switchEnable : softStartActive) !== v) begin
      step(1);
      n++;
      if (n > lim) begin
        num_errors++;
        end_sim;
      end
    end
  endtask
  // fault kinds: overcurrent, short, overvoltage, over-temp, enable low
  task automatic setFault(input int k, input logic v);
    case (k)
      0: cmpOverCurrent <= v;
      1: cmpFbLow <= v;
      2: cmpOverVolt <= v;
      3: cmpOverTemp <= v;
      default: enableIn <= !v;
    endcase
  endtask
  // ---------
  // scenarios
  // ---------
  initial begin
    repeat (20) @(posedge sys_clk);
    chk("freq", freqSet, 6'h19);
    rstn <= 1'b1;
    @(posedge sys_clk);
    enableIn <= 1'b1;
    step(20);
    chk("sw", switchEnable, 1'b0);
    @(posedge sys_clk);
    dimMode <= 2'h2;
    waitFor(0, 1'b1, 24);
    chk("ilim", ilimSet, 6'h00);
    step(8);
    chk("sw", switchEnable, 1'b1);
    waitFor(1, 1'b0, 1100);
    chk("sslen", n >= 1000 && n <= 1024, 1'b1);
    chk("freq", freqSet, 6'h3F);
    @(posedge sys_clk);
    dimMode <= 2'h1;
    cmpFbOpenBand <= 1'b1;
    cmpSenseLow <= 1'b1;
    step(6);
    chk("flag", faultLine, 1'b0);
    chk("sw", switchEnable, 1'b1);
    @(posedge sys_clk);
    cmpFbOpenBand <= 1'b0;
    cmpSenseNegLow <= 1'b1;
    cmpFbLow <= 1'b1;
    step(6);
    chk("sw", switchEnable, 1'b1);
    @(posedge sys_clk);
    cmpSenseNegLow <= 1'b0;
    cmpFbLow <= 1'b0;
    // each serious fault and enable low from steady running, random hold time
    for (int k = 0; k < 5; k++) begin
      step(4);
      @(posedge sys_clk);
      setFault(k, 1'b1);
      cmpTenPercent <= $random(seed);
      h = 3 + ($random(seed) & 3);
      waitFor(0, 1'b0, (k == 1) ? 4 : 3);
      chk("load", loadDisconnectGate, 1'b0);
      step(h);
      setFault(k, 1'b0);
      waitFor(1, 1'b1, 200);
      chk("cool", n + h + 2 >= ((k < 2) ? 64 : 0), 1'b1);
      if (k == 0) begin
        @(posedge sys_clk);
        cmpFbLow <= 1'b1;
        step(6);
        chk("sw", switchEnable, 1'b1);
        @(posedge sys_clk);
        cmpFbLow <= 1'b0;
      end
      if (k != 3)
        chk("flag", faultLine, k == 4);
      waitFor(1, 1'b0, 1100);
      step(3);
      chk("flag", faultLine, 1'b1);
      chk("freq", freqSet, 6'h3F);
      chk("ilim", ilimSet, 6'h3F);
    end
    end_sim;
  end
  // hang guard
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
endmodule
